// >>> logic/mte_entry_access.v
// Entry data registers, static address table and lookup resolution of the switch MAC table.
`timescale 1ns/1ps
`include "mte_map.vh"
module mte_entry_access (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Management register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  // Destination address lookup request
  input wire dl_req,
  input wire [47:0] dl_mac,
  input wire [6:0] dl_fgid,
  input wire dl_mcast,
  input wire [6:0] dl_port_blocked,
  // Hashed lookup table result for the same lookup
  input wire hl_hit,
  input wire [31:0] hl_word1,
  input wire [31:0] hl_word2,
  // Source learning check
  input wire sl_req,
  input wire [31:0] sl_word1,
  // Aging pass over one learned entry word1
  input wire ag_req,
  input wire ag_access,
  input wire [31:0] ag_word1,
  // Lookup, learning check and aging results
  output reg dl_done_ff,
  output reg dl_drop_ff,
  output reg [6:0] dl_ports_ff,
  output reg [2:0] dl_pri_ff,
  output reg [2:0] dl_stg_ff,
  output reg sl_drop_ff,
  output reg [31:0] ag_word1_ff,
  output reg ag_remove_ff,
  // Hashed table operation request to the outside engine
  output reg hl_start_ff
);
  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_READ = 3'b100;
  localparam [2:0] STALE_RELOAD = 3'h7;
  reg [31:0] word1_ff, word2_ff, word3_ff, word4_ff;
  reg [7:0] ctrl_ff;
  reg [2:0] state_ff;
  reg [31:0] tbl1 [0:`MTE_SLOTS-1];
  reg [31:0] tbl2 [0:`MTE_SLOTS-1];
  reg [31:0] tbl3 [0:`MTE_SLOTS-1];
  reg [31:0] tbl4 [0:`MTE_SLOTS-1];
  wire [3:0] slot;
  wire go_busy;
  integer i;
  assign slot = ctrl_ff[`MTE_CTRL_SLOT_HI:0];
  assign go_busy = ctrl_ff[`MTE_CTRL_GO];
  // Control write value with only the low eight bits kept.
  wire [31:0] ctrl_wr_val;
  assign ctrl_wr_val = reg_wdata & `MTE_CTRL_MASK;

  // --------------------------------------------------------------------------
  // Register writes and static table operations
  // --------------------------------------------------------------------------
  // Entry words keep only writable bits; reserved bits stay zero.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      word1_ff <= `MTE_ZERO32;
      word2_ff <= `MTE_ZERO32;
      word3_ff <= `MTE_ZERO32;
      word4_ff <= `MTE_ZERO32;
      ctrl_ff <= 8'h00;
      state_ff <= ST_IDLE;
      hl_start_ff <= 1'b0;
      for (i = 0; i < `MTE_SLOTS; i = i + 1) begin
        tbl1[i] <= `MTE_ZERO32;
        tbl2[i] <= `MTE_ZERO32;
        tbl3[i] <= `MTE_ZERO32;
        tbl4[i] <= `MTE_ZERO32;
      end
    end else begin
      hl_start_ff <= 1'b0;
      if (reg_wr && state_ff == ST_IDLE) begin
        case (reg_addr)
          `MTE_OFS_WORD1: word1_ff <= reg_wdata & `MTE_W1_MASK;
          `MTE_OFS_WORD2: word2_ff <= reg_wdata & `MTE_W2_MASK;
          `MTE_OFS_WORD3: word3_ff <= reg_wdata & `MTE_W3_MASK;
          `MTE_OFS_WORD4: word4_ff <= reg_wdata & `MTE_W4_MASK;
          `MTE_OFS_CTRL: begin
            if (!go_busy) begin
              ctrl_ff <= ctrl_wr_val[7:0];
              if (reg_wdata[`MTE_CTRL_GO] && reg_wdata[`MTE_CTRL_TBL]) begin
                hl_start_ff <= 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      case (state_ff)
        ST_IDLE: begin
          if (go_busy) begin
            if (ctrl_ff[`MTE_CTRL_TBL]) begin
              ctrl_ff[`MTE_CTRL_GO] <= 1'b0; // Other table is handled outside.
            end else if (ctrl_ff[`MTE_CTRL_ACT]) begin
              state_ff <= ST_READ;
            end else begin
              state_ff <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          tbl1[slot] <= word1_ff;
          tbl2[slot] <= word2_ff;
          tbl3[slot] <= word3_ff;
          tbl4[slot] <= word4_ff;
          ctrl_ff[`MTE_CTRL_GO] <= 1'b0;
          state_ff <= ST_IDLE;
        end
        ST_READ: begin
          word1_ff <= tbl1[slot];
          word2_ff <= tbl2[slot];
          word3_ff <= tbl3[slot];
          word4_ff <= tbl4[slot];
          ctrl_ff[`MTE_CTRL_GO] <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Read data is registered one cycle after the strobe.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= `MTE_ZERO32;
    end else if (reg_rd) begin
      case (reg_addr)
        `MTE_OFS_WORD1: reg_rdata_ff <= word1_ff;
        `MTE_OFS_WORD2: reg_rdata_ff <= word2_ff;
        `MTE_OFS_WORD3: reg_rdata_ff <= word3_ff;
        `MTE_OFS_WORD4: reg_rdata_ff <= word4_ff;
        `MTE_OFS_CTRL: reg_rdata_ff <= {24'h00_0000, ctrl_ff};
        default: reg_rdata_ff <= `MTE_ZERO32;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Static table search
  // --------------------------------------------------------------------------
  wire [`MTE_SLOTS-1:0] slot_hit;
  genvar g;
  generate
    for (g = 0; g < `MTE_SLOTS; g = g + 1) begin : g_slot
      mte_slot_match u_match (
        .word1(tbl1[g]),
        .word2(tbl2[g]),
        .word3(tbl3[g]),
        .word4(tbl4[g]),
        .key_mac(dl_mac),
        .key_fgid(dl_fgid),
        .key_mcast(dl_mcast),
        .hit(slot_hit[g])
      );
    end
  endgenerate

  // Lowest hit slot wins among static entries.
  reg st_hit;
  reg [31:0] st_w1, st_w2;
  integer k;
  always @* begin
    st_hit = 1'b0;
    st_w1 = `MTE_ZERO32;
    st_w2 = `MTE_ZERO32;
    for (k = `MTE_SLOTS - 1; k >= 0; k = k - 1) begin
      if (slot_hit[k]) begin
        st_hit = 1'b1;
        st_w1 = tbl1[k];
        st_w2 = tbl2[k];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Lookup resolution
  // --------------------------------------------------------------------------
  // A learned hashed entry counts only with nonzero staleness.
  wire hl_pinned, hl_usable, hl_wins;
  reg [31:0] r_w1, r_w2;
  reg r_hit;
  assign hl_pinned = hl_hit & hl_word1[`MTE_W1_PIN];
  assign hl_usable = hl_hit & (hl_pinned | (hl_word1[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO] != 3'h0));
  assign hl_wins = hl_pinned | (hl_usable & ~st_hit);
  always @* begin
    r_hit = st_hit | hl_usable;
    r_w1 = hl_wins ? hl_word1 : st_w1;
    r_w2 = hl_wins ? hl_word2 : st_w2;
  end

  // Results are registered one cycle after the request.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dl_done_ff <= 1'b0;
      dl_drop_ff <= 1'b0;
      dl_ports_ff <= 7'h00;
      dl_pri_ff <= 3'h0;
      dl_stg_ff <= 3'h0;
      sl_drop_ff <= 1'b0;
      ag_word1_ff <= `MTE_ZERO32;
      ag_remove_ff <= 1'b0;
    end else begin
      dl_done_ff <= dl_req;
      if (dl_req) begin
        dl_drop_ff <= r_hit & r_w1[`MTE_W1_DSTDROP];
        dl_ports_ff <= r_hit ? (r_w2[6:0] & (r_w2[`MTE_W1_BYPASS] ? 7'h7f : ~dl_port_blocked)) : 7'h00;
        dl_pri_ff <= r_w1[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO];
        dl_stg_ff <= r_w1[`MTE_W1_STG_HI:0];
      end
      sl_drop_ff <= sl_req & sl_word1[`MTE_W1_SRCDROP];
      if (ag_req) begin
        ag_word1_ff <= ag_word1;
        ag_remove_ff <= 1'b0;
        if (!ag_word1[`MTE_W1_PIN]) begin
          if (ag_access) begin
            ag_word1_ff[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO] <= STALE_RELOAD;
          end else if (ag_word1[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO] != 3'h0) begin
            ag_word1_ff[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO] <= ag_word1[`MTE_W1_PRI_HI:`MTE_W1_PRI_LO] - 3'h1;
          end else begin
            ag_remove_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule // mte_entry_access

// >>> common/mte_map.vh
// Register offsets, field positions and control codes of the MAC table entry access block.
`ifndef MTE_MAP_VH
`define MTE_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MTE_OFS_WORD1 12'h0420
`define MTE_OFS_WORD2 12'h0424
`define MTE_OFS_WORD3 12'h0428
`define MTE_OFS_WORD4 12'h042c
`define MTE_OFS_CTRL 12'h041c
// ----------------------------------------------------------------------------
// Write masks of the entry words and the control register
// ----------------------------------------------------------------------------
`define MTE_W1_MASK 32'hfc00_0007
`define MTE_W2_MASK 32'hc000_007f
`define MTE_W3_MASK 32'h007f_ffff
`define MTE_W4_MASK 32'hffff_ffff
`define MTE_CTRL_MASK 32'h0000_00ff
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MTE_W1_PIN 31
`define MTE_W1_SRCDROP 30
`define MTE_W1_DSTDROP 29
`define MTE_W1_PRI_HI 28
`define MTE_W1_PRI_LO 26
`define MTE_W1_STG_HI 2
`define MTE_W1_BYPASS 31
`define MTE_W2_MCFG 30
`define MTE_W3_FGID_HI 22
`define MTE_W3_FGID_LO 16
`define MTE_CTRL_SLOT_HI 3
`define MTE_CTRL_TBL 4
`define MTE_CTRL_ACT 5
`define MTE_CTRL_GO 7
// ----------------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------------
`define MTE_SLOTS 16
`define MTE_ZERO32 32'h0000_0000
`endif

// >>> logic/mte_slot_match.v
// One static table slot compared against a destination address lookup.
`timescale 1ns/1ps
`include "mte_map.vh"
module mte_slot_match (
  // Slot contents
  input wire [31:0] word1,
  input wire [31:0] word2,
  input wire [31:0] word3,
  input wire [31:0] word4,
  // Lookup key
  input wire [47:0] key_mac,
  input wire [6:0] key_fgid,
  input wire key_mcast,
  // Result
  output wire hit
);
  // The filter group takes part only for multicast with its enable set.
  wire use_fgid;
  assign use_fgid = word2[`MTE_W2_MCFG] & key_mcast;
  // A slot hits only when valid and the address matches.
  assign hit = word1[`MTE_W1_PIN] & ({word3[15:0], word4} == key_mac) &
               (~use_fgid | (word3[`MTE_W3_FGID_HI:`MTE_W3_FGID_LO] == key_fgid));
endmodule // mte_slot_match

// >>> verification/mte_monitor.sv
// Checker of the lookup, learning, aging and hashed start outputs.
`timescale 1ns/1ps
module mte_monitor (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Inputs of the block
  input wire reg_wr,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire dl_req,
  input wire [6:0] dl_port_blocked,
  input wire hl_hit,
  input wire [31:0] hl_word1,
  input wire [31:0] hl_word2,
  input wire sl_req,
  input wire [31:0] sl_word1,
  input wire ag_req,
  input wire ag_access,
  input wire [31:0] ag_word1,
  // Outputs of the block
  input wire dl_done_ff,
  input wire dl_drop_ff,
  input wire [6:0] dl_ports_ff,
  input wire [2:0] dl_pri_ff,
  input wire [2:0] dl_stg_ff,
  input wire sl_drop_ff,
  input wire [31:0] ag_word1_ff,
  input wire ag_remove_ff,
  input wire hl_start_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // A pinned hashed hit without drop, and a learned entry aged without access.
  sequence s_pin_hit; dl_req && hl_hit && hl_word1[31] && !hl_word1[29]; endsequence
  sequence s_aged; ag_req && !ag_word1[31] && !ag_access && ag_word1[28:26] > 3'h1; endsequence
  property p_done; dl_done_ff == $past(dl_req); endproperty
  a_done: assert property (p_done) else $error("lookup done mismatch");
  property p_pin_attr; s_pin_hit |=> !dl_drop_ff && dl_stg_ff == $past(hl_word1[2:0]); endproperty
  a_pin_attr: assert property (p_pin_attr) else $error("pinned hit fields");
  property p_bypass; s_pin_hit ##0 hl_word2[31] |=> dl_ports_ff == $past(hl_word2[6:0]); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass ports");
  property p_mask; s_pin_hit ##0 !hl_word2[31] |=> dl_ports_ff == $past(hl_word2[6:0] & ~dl_port_blocked); endproperty
  a_mask: assert property (p_mask) else $error("masked ports");
  property p_dst_drop; dl_req && hl_hit && hl_word1[31] && hl_word1[29] |=> dl_drop_ff; endproperty
  a_dst_drop: assert property (p_dst_drop) else $error("target drop");
  property p_src; sl_req |=> sl_drop_ff == $past(sl_word1[30]); endproperty
  a_src: assert property (p_src) else $error("source drop");
  property p_age_pin; ag_req && ag_word1[31] |=> ag_word1_ff == $past(ag_word1) && !ag_remove_ff; endproperty
  a_age_pin: assert property (p_age_pin) else $error("pinned entry aged");
  property p_age_acc; ag_req && !ag_word1[31] && ag_access |=> ag_word1_ff[28:26] == 3'h7; endproperty
  a_age_acc: assert property (p_age_acc) else $error("staleness reload");
  property p_age_dec; s_aged |=> ag_word1_ff[28:26] == $past(ag_word1[28:26]) - 3'h1 && !ag_remove_ff; endproperty
  a_age_dec: assert property (p_age_dec) else $error("staleness decrement");
  property p_hl_go; reg_wr && reg_addr == 12'h041c && reg_wdata[7] && reg_wdata[4] |=> hl_start_ff; endproperty
  a_hl_go: assert property (p_hl_go) else $error("hashed start");
endmodule // mte_monitor
bind mte_entry_access mte_monitor mon_u (.*);

// >>> verification/mte_host_model.sv
// Host processor model driving the management register port.
`timescale 1ns/1ps
module mte_host_model (
  // Clock
  input wire clock,
  // Management port
  output reg reg_wr,
  output reg reg_rd,
  output reg [11:0] reg_addr,
  output reg [31:0] reg_wdata,
  input wire [31:0] reg_rdata_ff
);
  // Port idles with scrambled address and data.
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, 12'h0bad, 32'h5a5a_a5a5};
  end
  // One write pulse; address and data are inverted once released.
  task wr(input [11:0] a, input [31:0] d);
    @(posedge clock);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clock);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  // One read pulse; data is taken the cycle after.
  task rd(input [11:0] a, output [31:0] d);
    @(posedge clock);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clock);
    #1 {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rdata_ff;
  endtask
  // Starts a static table operation, then polls until the go bit clears.
  task op(input [7:0] c, output ok);
    reg [31:0] d;
    integer n;
    begin
      wr(12'h041c, {24'h00_0000, c});
      d = 32'h0000_0080;
      for (n = 0; n < 8 && d[7] !== 1'b0; n = n + 1) rd(12'h041c, d);
      ok = (d[7] === 1'b0);
    end
  endtask
endmodule // mte_host_model

// >>> verification/tb.sv
// Self-checking bench of the MAC table entry access block.
`timescale 1ns/1ps
`include "mte_map.vh"
module tb;
  // Bench-driven inputs, scratch values and counters.
  reg clock, sys_rst, dl_req, dl_mcast, hl_hit, sl_req, ag_req, ag_access, ok;
  reg [47:0] dl_mac;
  reg [6:0] dl_fgid, dl_port_blocked, blk;
  reg [31:0] hl_word1, hl_word2, sl_word1, ag_word1, r, d, h1, h2, seed_ff;
  reg [31:0] w [0:3];
  reg [3:0] slot;
  integer error_cnt, total_checks, i, k, m;
  reg [31:0] msk [0:3];
  // Host-owned port and block outputs.
  wire reg_wr, reg_rd, dl_done_ff, dl_drop_ff, sl_drop_ff, ag_remove_ff, hl_start_ff;
  wire [11:0] reg_addr;
  wire [31:0] reg_wdata, reg_rdata_ff, ag_word1_ff;
  wire [6:0] dl_ports_ff;
  wire [2:0] dl_pri_ff, dl_stg_ff;
  mte_entry_access dut_u (.*);
  mte_host_model host_u (.*);
  // Next word of the bench shift register.
  function automatic logic [31:0] rnd();
    seed_ff = {seed_ff[30:0], seed_ff[31] ^ seed_ff[21] ^ seed_ff[1] ^ seed_ff[0]};
    return seed_ff;
  endfunction
  // Ports a matching entry forwards to under the given blocking state.
  function automatic logic [6:0] fwd(input [31:0] w2, input [6:0] b);
    return w2[31] ? w2[6:0] : w2[6:0] & ~b;
  endfunction
  // Compares one value and reports a mismatch at once.
  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One lookup request; the answer is settled one cycle later.
  task look(input [47:0] mac, input hit, input [31:0] a, input [31:0] b, input [6:0] bl);
    {dl_req, dl_mac, hl_hit, hl_word1, hl_word2, dl_port_blocked} = {1'b1, mac, hit, a, b, bl};
    @(posedge clock);
    #1 {dl_req, dl_mac} = {1'b0, ~mac};
    chk(dl_done_ff, 1'b1);
  endtask
  // Clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Watchdog well beyond the roughly two hundred cycles the tests take.
  initial begin
    #100000 error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    {error_cnt, total_checks, seed_ff, sys_rst} = {32'd0, 32'd0, 32'h0000_8938, 1'b1};
    {dl_req, dl_mac, dl_fgid, dl_mcast, dl_port_blocked, hl_hit, hl_word1, hl_word2} = '0;
    {sl_req, sl_word1, ag_req, ag_access, ag_word1} = '0;
    {msk[0], msk[1], msk[2], msk[3]} = {`MTE_W1_MASK, `MTE_W2_MASK, `MTE_W3_MASK, `MTE_W4_MASK};
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 4; i++) host_u.wr(12'h0420 + 12'(4 * i), 32'hffff_ffff);
    for (i = 0; i < 4; i++) begin
      host_u.rd(12'h0420 + 12'(4 * i), d);
      chk(d, msk[i]);
    end
    // Slots at both ends and at random are stored, wiped, read back and looked up.
    for (k = 0; k < 4; k++) begin
      r = rnd();
      slot = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : r[3:0];
      for (i = 0; i < 4; i++) begin
        w[i] = rnd() & msk[i];
        if (i == 0) w[0] = (w[0] | 32'h8000_0000) & 32'hdfff_ffff;
        if (i == 1 && k == 1) w[1] = w[1] | 32'h4000_0000;
        host_u.wr(12'h0420 + 12'(4 * i), w[i]);
      end
      host_u.op({4'h8, slot}, ok);
      chk(ok, 1'b1);
      for (i = 0; i < 4; i++) host_u.wr(12'h0420 + 12'(4 * i), 32'h0000_0000);
      host_u.op({4'ha, slot}, ok);
      chk(ok, 1'b1);
      for (i = 0; i < 4; i++) begin
        host_u.rd(12'h0420 + 12'(4 * i), d);
        chk(d, w[i]);
      end
      for (m = 0; m < 3; m++) begin
        // Hashed words are learned except the last, which is pinned and may carry a drop.
        h1 = rnd() & 32'h7fff_ffff | ((m == 2) ? 32'h8000_0000 : 32'h1c00_0000);
        h2 = rnd();
        r = rnd();
        blk = r[6:0];
        // The first lookup is multicast; its group is flipped by r[7], and always in the second slot.
        {dl_mcast, dl_fgid} = {m == 0, w[2][22:16] ^ {6'h00, r[7] | (k == 1)}};
        look({w[2][15:0], w[3]}, m != 0, h1, h2, blk);
        if (m == 2) chk({dl_drop_ff, dl_ports_ff}, {h1[29], fwd(h2, blk)});
        else if (m == 0 && w[1][30] && (r[7] | (k == 1))) chk({dl_drop_ff, dl_ports_ff}, 8'h00);
        else chk({dl_drop_ff, dl_pri_ff, dl_stg_ff, dl_ports_ff}, {w[0][29:26], w[0][2:0], fwd(w[1], blk)});
      end
    end
    // A slot with its valid flag cleared gives way to the learned entry.
    host_u.wr(12'h0420, w[0] & 32'h7fff_ffff);
    host_u.op({4'h8, slot}, ok);
    chk(ok, 1'b1);
    look({w[2][15:0], w[3]}, 1'b1, h1 & 32'h7fff_ffff | 32'h1c00_0000, h2, blk);
    chk(dl_ports_ff, fwd(h2, blk));
    // A learned entry whose staleness has run out is no hit at all.
    look({w[2][15:0], w[3]}, 1'b1, h1 & 32'h63ff_ffff, h2, blk);
    chk(dl_ports_ff, 32'h0000_0000);
    host_u.wr(12'h041c, 32'h0000_0090);
    // Back-to-back learning checks and aging passes, the first on a stale entry.
    for (k = 0; k < 16; k++) begin
      r = rnd();
      {sl_req, ag_req, ag_access, sl_word1} = {2'b11, r[0] & (k != 0), rnd()};
      ag_word1 = (k == 0) ? 32'h0000_0005 : rnd();
      @(posedge clock);
      #1 chk(sl_drop_ff, sl_word1[30]);
      if (k == 0) chk(ag_remove_ff, 1'b1);
    end
    {sl_req, ag_req} = 2'b00;
    tally_and_finish;
  end
endmodule // tb
